// File: rtl/fcc_feeder_ctl.sv
`timescale 1ns/1ps
// Notes on behaviour
// - contactor feeder: open input lost drops both relays
// - breaker: open lost drops A, closes B
// - no close while open input absent
// - contactor: close input energises matching relay
// - breaker: close B input ignored
// - close inputs momentary unless two-wire selected
// - test input freezes operation counter
// - flag open circuit or welded contactor
// - external close seals in, open drops
// - trip and alarm override displayed message
// - two idle minutes select default message
// - contactor closed lamp needs relay and status
// - breaker closed lamp from relay A, status A
// - open lamp from unhealthy status inputs
// - tripped lamp blocks closing until reset
// - alarm and fault lamps follow conditions
// - relay lamps mirror relay states
// - auto mode: only serial closes
// - hard-wired auto: auto close with permissive
// - manual: switches and keys, no serial close
// - open commands work in every mode
// - ten programmable switch inputs with functions
module fcc_feeder_ctl #(
  parameter longint IDLE_CYCLES = fcc_pkg::IDLE_CYC,  // display idle timeout
  parameter int     DEB_CYCLES  = fcc_pkg::DEB_CYC,   // debounce period
  parameter int     FB_CYCLES   = fcc_pkg::FB_CYC,    // status feedback window
  parameter int     NPROG       = 10                  // programmable inputs
) (
  input  wire logic        ref_clk,     // system clock, 100 MHz
  input  wire logic        srst,        // synchronous reset, active high
  input  wire logic        psel,        // apb select
  input  wire logic        penable,     // apb enable
  input  wire logic        pwrite,      // apb direction
  input  wire logic [7:0]  paddr,       // apb byte address
  input  wire logic [31:0] pwdata,      // apb write data
  output logic      [31:0] prdata,      // apb read data
  output logic             pready,      // apb ready
  output logic             pslverr,     // apb error on unmapped address
  input  wire logic [15:0] swPins,      // raw switch pins, fcc_sw_t order
  input  wire logic [3:0]  keys,        // open, reset, close a, close b keys
  input  wire logic        progRelay,   // programmable relay state
  input  wire logic        esdRelay,    // emergency shutdown relay state
  input  wire logic        anyKey,      // any keypad key press
  output logic             relayA_q,    // output relay A
  output logic             relayB_q,    // output relay B
  output fcc_pkg::fcc_lamp_t lamps_q,   // faceplate lamps
  output fcc_pkg::fcc_msg_t  msgSel_q   // message selected for display
);

  // synchroniser and debounce per switch pin
  logic [15:0] syncA_q, syncB_q;             // two-stage synchroniser
  logic [15:0] swDb_q;                        // debounced level
  logic [15:0] swPrev_q;                      // previous debounced level
  genvar gi;
  generate
    for (gi = 0; gi < 16; gi++)
    begin : g_deb
      logic [23:0] cnt_q;                     // stable-time counter
      always_ff @(posedge ref_clk)
      begin
        if (srst)
        begin
          cnt_q       <= 24'h000000;
          swDb_q[gi]  <= 1'b0;
        end
        else if (syncB_q[gi] == swDb_q[gi])
          cnt_q <= 24'h000000;
        else if (cnt_q >= 24'(DEB_CYCLES - 1))
        begin
          swDb_q[gi] <= syncB_q[gi];
          cnt_q      <= 24'h000000;
        end
        else
          cnt_q <= cnt_q + 24'h000001;
      end
    end
  endgenerate

  // synchroniser flops
  always_ff @(posedge ref_clk)
  begin
    syncA_q  <= srst ? 16'h0000 : swPins;
    syncB_q  <= srst ? 16'h0000 : syncA_q;
    swPrev_q <= srst ? 16'h0000 : swDb_q;
  end

  fcc_pkg::fcc_sw_t sw;                       // debounced view
  assign sw = swDb_q;

  // registers
  logic [31:0] ctrl_q, map_q, stats_q;
  logic [31:0] ext_q;                         // bit0 trip, bit1 alarm, bit2 fault, bit3 trip lockout
  logic        tripped_q, openCkt_q, welded_q, extClose_q, extOpen_q;

  wire        apbWr  = psel && penable && pwrite;
  wire        apbAcc = psel && penable;
  wire        hitCtrl = paddr == fcc_pkg::OFS_CTRL;
  wire        hitCmd  = paddr == fcc_pkg::OFS_CMD;
  wire        hitSt   = paddr == fcc_pkg::OFS_STATUS;
  wire        hitMap  = paddr == fcc_pkg::OFS_PSWMAP;
  wire        hitStat = paddr == fcc_pkg::OFS_STATS;
  wire        hitExt  = paddr == fcc_pkg::OFS_EXT;
  wire        mapped  = hitCtrl | hitCmd | hitSt | hitMap | hitStat | hitExt;
  // command strobes act once, at the first access-phase edge only
  wire [4:0]  cmd     = (apbWr && hitCmd && !pready) ? pwdata[4:0] : 5'h00;

  wire breaker = ctrl_q[fcc_pkg::CTRL_BREAKER];
  wire twoWire = ctrl_q[fcc_pkg::CTRL_TWOWIRE];
  fcc_pkg::fcc_mode_t mode;
  assign mode = fcc_pkg::fcc_mode_t'(ctrl_q[fcc_pkg::CTRL_MODE_LO +: 2]);

  // programmable function decode
  logic [7:0] progFn;                         // one bit per function, any input
  always_comb
  begin
    progFn = 8'h00;
    for (int i = 0; i < NPROG; i++)
      if (sw.prog[i])
        progFn[map_q[3*i +: 3]] = 1'b1;
  end
  wire lockRst = progFn[fcc_pkg::PF_LOCKRST];
  wire intlkOk = (map_q[29:0] == 30'h0) | progFn[fcc_pkg::PF_INTERLK];
  wire permit  = progFn[fcc_pkg::PF_PERMIT];
  wire testOn  = sw.test | progFn[fcc_pkg::PF_TEST];

  // close inputs: edge or level
  wire swCloseA = twoWire ? sw.closeA : (sw.closeA & ~swPrev_q[14]);
  wire swCloseB = twoWire ? sw.closeB : (sw.closeB & ~swPrev_q[13]);
  wire autoClA  = progFn[fcc_pkg::PF_AUTOCLA] & permit;
  wire autoClB  = progFn[fcc_pkg::PF_AUTOCLB] & permit;

  // close source qualified by mode
  wire localOk  = mode == fcc_pkg::MODE_MANUAL;
  wire serialOk = mode == fcc_pkg::MODE_AUTO;
  wire hwOk     = mode == fcc_pkg::MODE_HWAUTO;
  wire reqA = (localOk & (swCloseA | keys[1])) | (serialOk & cmd[fcc_pkg::CMD_CLOSEA])
            | (hwOk & autoClA);
  wire reqB = (localOk & (swCloseB | keys[0])) | (serialOk & cmd[fcc_pkg::CMD_CLOSEB])
            | (hwOk & autoClB);
  wire closeGate = sw.openOk & ~tripped_q & intlkOk;
  wire doCloseA  = closeGate & reqA;
  wire doCloseB  = closeGate & reqB & ~breaker;
  wire openCmd   = keys[3] | cmd[fcc_pkg::CMD_OPEN] | ~sw.openOk;
  wire tripEv    = ext_q[0] & ~tripped_q;

  // external operation: status changes without a pending command
  logic        pendClose_q, pendOpen_q;
  logic [31:0] fbCnt_q;
  wire statAny = breaker ? sw.statA : (sw.statA | sw.statB);
  wire statRise = statAny & ~(breaker ? swPrev_q[11] : (swPrev_q[11] | swPrev_q[10]));
  wire statFall = ~statAny & (breaker ? swPrev_q[11] : (swPrev_q[11] | swPrev_q[10]));
  wire extCl = statRise & ~pendClose_q;
  wire extOp = statFall & ~pendOpen_q & ~openCmd & ~tripEv;

  // output relays
  always_ff @(posedge ref_clk)
  begin
    if (srst)
    begin
      relayA_q <= 1'b0;
      relayB_q <= 1'b0;
    end
    else if (tripEv | openCmd | extOp)
    begin
      relayA_q <= 1'b0;
      relayB_q <= breaker & (openCmd | tripEv);
    end
    else if (doCloseA | (extCl & ~relayB_q))
    begin
      relayA_q <= 1'b1;
      if (breaker)
        relayB_q <= 1'b0;
    end
    else if (doCloseB)
      relayB_q <= 1'b1;
    else if (twoWire & localOk & ~breaker & ~sw.closeA & ~sw.closeB)
    begin
      relayA_q <= 1'b0;
      relayB_q <= 1'b0;
    end
  end

  // discrepancy watch after commands
  always_ff @(posedge ref_clk)
  begin
    if (srst)
    begin
      pendClose_q <= 1'b0;
      pendOpen_q  <= 1'b0;
      fbCnt_q     <= 32'h0000_0000;
      openCkt_q   <= 1'b0;
      welded_q    <= 1'b0;
      extClose_q  <= 1'b0;
      extOpen_q   <= 1'b0;
    end
    else
    begin
      if (doCloseA | doCloseB)
      begin
        pendClose_q <= 1'b1;
        pendOpen_q  <= 1'b0;
        fbCnt_q     <= 32'h0000_0000;
      end
      else if ((openCmd | tripEv) & (relayA_q | relayB_q))
      begin
        pendOpen_q  <= 1'b1;
        pendClose_q <= 1'b0;
        fbCnt_q     <= 32'h0000_0000;
      end
      else if (pendClose_q & statRise)
        pendClose_q <= 1'b0;
      else if (pendOpen_q & statFall)
        pendOpen_q <= 1'b0;
      else if ((pendClose_q | pendOpen_q) & (fbCnt_q >= 32'(FB_CYCLES - 1)))
      begin
        pendClose_q <= 1'b0;
        pendOpen_q  <= 1'b0;
      end
      else if (pendClose_q | pendOpen_q)
        fbCnt_q <= fbCnt_q + 32'h0000_0001;
      // flags: set wins over serial clear
      openCkt_q  <= (pendClose_q & ~statRise & (fbCnt_q >= 32'(FB_CYCLES - 1)))
                  | (openCkt_q & ~cmd[fcc_pkg::CMD_FLAGCLR]);
      welded_q   <= (pendOpen_q & ~statFall & (fbCnt_q >= 32'(FB_CYCLES - 1)))
                  | (welded_q & ~cmd[fcc_pkg::CMD_FLAGCLR]);
      extClose_q <= extCl | (extClose_q & ~cmd[fcc_pkg::CMD_FLAGCLR]);
      extOpen_q  <= extOp | (extOpen_q & ~cmd[fcc_pkg::CMD_FLAGCLR]);
    end
  end

  // trip latch and operation counter
  wire rstReq = keys[2] | cmd[fcc_pkg::CMD_RESET];
  wire tripClr = ~ext_q[0] & (ext_q[3] ? (lockRst | cmd[fcc_pkg::CMD_RESET]) : (rstReq | lockRst));
  always_ff @(posedge ref_clk)
  begin
    if (srst)
      tripped_q <= 1'b0;
    else
      tripped_q <= tripEv | (tripped_q & ~tripClr);
    if (srst)
      stats_q <= 32'h0000_0000;
    else if ((doCloseA | doCloseB | (tripEv & relayA_q)) & ~testOn)
      stats_q <= stats_q + 32'h0000_0001;
  end

  // display message selection
  logic [63:0] idle_q;                        // wide: the default timeout overflows 32 bits
  wire feederClosed = lamps_q.closed;
  always_ff @(posedge ref_clk)
  begin
    if (srst | anyKey)
      idle_q <= 64'h0000_0000_0000_0000;
    else if (idle_q < 64'(IDLE_CYCLES))
      idle_q <= idle_q + 64'h0000_0000_0000_0001;
    if (srst)
      msgSel_q <= fcc_pkg::MSG_STATUS;
    else if (tripped_q | ext_q[0])
      msgSel_q <= fcc_pkg::MSG_TRIP;
    else if (ext_q[1])
      msgSel_q <= fcc_pkg::MSG_ALARM;
    else if (idle_q >= 64'(IDLE_CYCLES - 1))
      msgSel_q <= feederClosed ? fcc_pkg::MSG_USER : fcc_pkg::MSG_STATUS;
  end

  // lamps
  fcc_pkg::fcc_lamp_t lampD;
  always_comb
  begin
    lampD = '0;
    lampD.closed  = breaker ? (relayA_q & sw.statA)
                  : ((relayA_q & sw.statA) | (relayB_q & sw.statB));
    lampD.open    = breaker ? ~sw.statA : (~sw.statA & ~sw.statB);
    lampD.tripped = tripped_q;
    lampD.alarm   = ext_q[1];
    lampD.fault   = ext_q[2];
    lampD.relayA  = relayA_q;
    lampD.relayB  = relayB_q;
    lampD.assignable_output_lamp  = progRelay;
    lampD.emergency_shutdown_lamp = esdRelay;
    lampD.auto    = mode != fcc_pkg::MODE_MANUAL;
    lampD.manual  = mode == fcc_pkg::MODE_MANUAL;
  end
  always_ff @(posedge ref_clk)
    lamps_q <= srst ? '0 : lampD;

  // apb slave, one wait state
  wire [31:0] rdMux = hitCtrl ? ctrl_q
                    : hitSt   ? {20'h0, extOpen_q, extClose_q, welded_q, openCkt_q,
                                 tripped_q, msgSel_q, feederClosed, testOn, sw.openOk,
                                 relayB_q, relayA_q}
                    : hitMap  ? map_q
                    : hitStat ? stats_q
                    : hitExt  ? ext_q
                    : 32'h0000_0000;
  always_ff @(posedge ref_clk)
  begin
    if (srst)
    begin
      ctrl_q  <= fcc_pkg::CTRL_RST;
      map_q   <= fcc_pkg::PSWMAP_RST;
      ext_q   <= 32'h0000_0000;
      pready  <= 1'b0;
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end
    else
    begin
      pready  <= apbAcc & ~pready;
      pslverr <= apbAcc & ~pready & ~mapped;
      prdata  <= (apbAcc & ~pready & ~pwrite) ? rdMux : 32'h0000_0000;
      if (apbWr & pready & hitCtrl)
        ctrl_q <= {28'h0, pwdata[3:0]};
      if (apbWr & pready & hitMap)
        map_q <= {2'h0, pwdata[29:0]};
      if (apbWr & pready & hitExt)
        ext_q <= {28'h0, pwdata[3:0]};
    end
  end

  // assertions
  a_open_drops: assert property (@(posedge ref_clk) disable iff (srst)
    (!sw.openOk && !breaker) |=> !relayA_q && !relayB_q)
    else $error("relays not dropped on lost open input");
  a_brk_open: assert property (@(posedge ref_clk) disable iff (srst)
    (!sw.openOk && breaker) |=> !relayA_q && relayB_q)
    else $error("breaker open sequence wrong");
  a_trip_blocks: assert property (@(posedge ref_clk) disable iff (srst)
    (tripped_q && !relayA_q) |=> !relayA_q)
    else $error("closed while tripped");
  a_test_stats: assert property (@(posedge ref_clk) disable iff (srst)
    testOn |=> stats_q == $past(stats_q))
    else $error("counter moved in test");
  a_brk_closeb: assert property (@(posedge ref_clk) disable iff (srst)
    (breaker && !relayB_q && sw.openOk && !tripEv && !openCmd) |=> !relayB_q)
    else $error("breaker relay B closed by close B");
  a_lamp_mirror: assert property (@(posedge ref_clk) disable iff (srst)
    ##1 lamps_q.relayA == $past(relayA_q))
    else $error("relay A lamp mismatch");
  a_trip_msg: assert property (@(posedge ref_clk) disable iff (srst)
    ext_q[0] |=> msgSel_q == fcc_pkg::MSG_TRIP)
    else $error("trip message not shown");
  a_manual_serial: assert property (@(posedge ref_clk) disable iff (srst)
    (localOk && !relayA_q && !(swCloseA | keys[1])) |=> !relayA_q || $past(extCl))
    else $error("serial close acted in manual");

endmodule : fcc_feeder_ctl

// File: rtl/fcc_pkg.sv
package fcc_pkg;

  // register byte offsets
  localparam logic [7:0] OFS_CTRL   = 8'h00;  // control: feeder type, mode, two-wire
  localparam logic [7:0] OFS_CMD    = 8'h04;  // serial command strobes
  localparam logic [7:0] OFS_STATUS = 8'h08;  // relay, lamp and flag state
  localparam logic [7:0] OFS_PSWMAP = 8'h0C;  // programmable input functions, 3 bits each
  localparam logic [7:0] OFS_STATS  = 8'h10;  // operation counter
  localparam logic [7:0] OFS_EXT    = 8'h14;  // trip, alarm, fault inputs from protection

  // control field positions
  localparam int CTRL_BREAKER = 0;  // 1: circuit-breaker feeder
  localparam int CTRL_MODE_LO = 1;  // two-bit control mode
  localparam int CTRL_TWOWIRE = 3;  // maintained close inputs

  // command bit positions
  localparam int CMD_CLOSEA = 0;
  localparam int CMD_CLOSEB = 1;
  localparam int CMD_OPEN   = 2;
  localparam int CMD_RESET  = 3;
  localparam int CMD_FLAGCLR = 4;   // clear discrepancy and external flags

  // programmable input functions
  localparam logic [2:0] PF_NONE     = 3'h0;
  localparam logic [2:0] PF_ACCESS   = 3'h1;
  localparam logic [2:0] PF_LOCKRST  = 3'h2;
  localparam logic [2:0] PF_INTERLK  = 3'h3;
  localparam logic [2:0] PF_AUTOCLA  = 3'h4;
  localparam logic [2:0] PF_AUTOCLB  = 3'h5;
  localparam logic [2:0] PF_PERMIT   = 3'h6;
  localparam logic [2:0] PF_TEST     = 3'h7;

  // reset values
  localparam logic [31:0] CTRL_RST   = 32'h0000_0000;
  localparam logic [31:0] PSWMAP_RST = 32'h0000_0000;

  // timing
  localparam int CLK_HZ       = 100_000_000;
  localparam int IDLE_MINUTES = 2;
  localparam longint IDLE_CYC = longint'(IDLE_MINUTES) * 60 * CLK_HZ;
  localparam int DEB_MS       = 10;
  localparam int DEB_CYC      = DEB_MS * (CLK_HZ / 1000);
  localparam int FB_MS        = 500;  // time allowed for status feedback
  localparam int FB_CYC       = FB_MS * (CLK_HZ / 1000);

  typedef enum logic [1:0] {
    MODE_MANUAL = 2'b00,
    MODE_AUTO   = 2'b01,
    MODE_HWAUTO = 2'b10
  } fcc_mode_t;

  typedef enum logic [1:0] {
    MSG_USER   = 2'b00,
    MSG_STATUS = 2'b01,
    MSG_ALARM  = 2'b10,
    MSG_TRIP   = 2'b11
  } fcc_msg_t;

  // faceplate lamps
  typedef struct packed {
    logic closed;
    logic open;
    logic tripped;
    logic alarm;
    logic fault;
    logic relayA;
    logic relayB;
    logic assignable_output_lamp;
    logic emergency_shutdown_lamp;
    logic auto;
    logic manual;
  } fcc_lamp_t;

  // debounced switch inputs
  typedef struct packed {
    logic       openOk;
    logic       closeA;
    logic       closeB;
    logic       test;
    logic       statA;
    logic       statB;
    logic [9:0] prog;
  } fcc_sw_t;

endpackage : fcc_pkg

// File: verif/fcc_contactor_model.sv
`timescale 1ns/1ps
module fcc_contactor_model #(
  parameter int DLY = 3  // coil to auxiliary contact travel, cycles
) (
  input  wire logic ref_clk,  // system clock
  input  wire logic relayA,   // coil a drive
  input  wire logic relayB,   // coil b drive
  input  wire logic stuck,    // contacts frozen, as if welded
  output logic      statA,    // auxiliary contact a
  output logic      statB     // auxiliary contact b
);
  logic [DLY-1:0] pipeA = '0;  // armature travel a
  logic [DLY-1:0] pipeB = '0;  // armature travel b
  // armature follows its coil after the travel time unless frozen
  always_ff @(posedge ref_clk)
  begin
    if (!stuck)
    begin
      pipeA <= {pipeA[DLY-2:0], relayA};
      pipeB <= {pipeB[DLY-2:0], relayB};
    end
  end
  assign statA = pipeA[DLY-1];  // contact a closed when armature home
  assign statB = pipeB[DLY-1];  // contact b closed when armature home
endmodule : fcc_contactor_model

// File: verif/fcc_feeder_ctl_tb.sv
`timescale 1ns/1ps
module fcc_feeder_ctl_tb;
  logic                ref_clk;    // system clock
  logic                srst;       // sync reset
  logic                psel;       // apb select
  logic                penable;    // apb enable
  logic                pwrite;     // apb direction
  logic [7:0]          paddr;      // apb address
  logic [31:0]         pwdata;     // apb write data
  logic [31:0]         prdata;     // apb read data
  logic                pready;     // apb ready
  logic                pslverr;    // apb error
  logic [3:0]          sw;         // open ok, close a, close b, test
  logic [9:0]          prog;       // programmable inputs
  logic [3:0]          keys;       // open, reset, close a, close b
  logic                progRelay;  // assignable relay state
  logic                esdRelay;   // shutdown relay state
  logic                anyKey;     // key activity
  logic                stuck;      // freeze the contactor
  logic                statA;      // aux contact a
  logic                statB;      // aux contact b
  logic                relayA;     // relay a drive
  logic                relayB;     // relay b drive
  fcc_pkg::fcc_lamp_t  lamps;      // faceplate lamps
  fcc_pkg::fcc_msg_t   msgSel;     // displayed message
  logic [31:0]         rdat;       // last read data
  logic                rerr;       // last error flag
  logic [31:0]         s0;         // saved counter
  int                  err_count;  // mismatches
  int                  checks_done;  // comparisons

  fcc_feeder_ctl #(.IDLE_CYCLES(1000), .DEB_CYCLES(2), .FB_CYCLES(20)) uut (
    .ref_clk(ref_clk), .srst(srst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .swPins({sw, statA, statB, prog}), .keys(keys), .progRelay(progRelay),
    .esdRelay(esdRelay), .anyKey(anyKey), .relayA_q(relayA), .relayB_q(relayB),
    .lamps_q(lamps), .msgSel_q(msgSel));

  fcc_contactor_model #(.DLY(3)) plant (
    .ref_clk(ref_clk), .relayA(relayA), .relayB(relayB), .stuck(stuck),
    .statA(statA), .statB(statB));

  // free running 100 MHz clock
  initial
  begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end

  task tick(input int n);
    repeat (n) @(posedge ref_clk);
  endtask : tick

  task chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
    checks_done++;
    if (got !== exp)
    begin
      err_count++;
      $display("CHECK FAILED t=%0t %s got %0h exp %0h", $time, msg, got, exp);
    end
  endtask : chk

  // one apb transfer, held until pready is sampled high
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    @(posedge ref_clk);
    while (pready !== 1'b1 && n < 50)
    begin
      @(posedge ref_clk);
      n++;
    end
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge ref_clk);
  endtask : apb

  // debounced switch pulse, long enough to be taken
  task pulse(input int i);
    sw[i] <= 1'b1;
    tick(12);
    sw[i] <= 1'b0;
    tick(12);
  endtask : pulse

  task t_regs;
    apb(1'b0, fcc_pkg::OFS_CTRL, 32'h0);
    chk(rdat, fcc_pkg::CTRL_RST, "ctrl reset");
    apb(1'b0, fcc_pkg::OFS_PSWMAP, 32'h0);
    chk(rdat, fcc_pkg::PSWMAP_RST, "map reset");
    apb(1'b0, 8'h40, 32'h0);
    chk({rerr, rdat}, {1'b1, 32'h0}, "unmapped");
    $display("regs done");
  endtask : t_regs

  task t_manual;
    pulse(2);
    chk(relayA, 1'b0, "close w/o open");
    sw[3] <= 1'b1;
    progRelay <= 1'b1;
    tick(12);
    pulse(2);
    chk(relayA, 1'b1, "close a");
    chk({lamps.relayA, lamps.closed, lamps.manual}, 3'h7, "lamps");
    chk(lamps.assignable_output_lamp, 1'b1, "prog lamp");
    apb(1'b1, fcc_pkg::OFS_CMD, 32'h2);
    tick(3);
    chk(relayB, 1'b0, "serial close manual");
    sw[3] <= 1'b0;
    tick(16);
    chk({relayA, relayB}, 2'h0, "open lost");
    chk(lamps.open, 1'b1, "open lamp");
    $display("manual done");
  endtask : t_manual

  task t_breaker;
    apb(1'b1, fcc_pkg::OFS_CTRL, 32'h1);
    sw[3] <= 1'b1;
    tick(12);
    pulse(2);
    pulse(1);
    chk(relayB, 1'b0, "breaker close b");
    chk({relayA, lamps.closed}, 2'h3, "breaker closed");
    sw[3] <= 1'b0;
    tick(12);
    chk({relayA, relayB}, 2'h1, "breaker open lost");
    sw[3] <= 1'b1;
    $display("breaker done");
  endtask : t_breaker

  task t_auto;
    apb(1'b1, fcc_pkg::OFS_CTRL, 32'h2);
    sw[0] <= 1'b1;
    tick(12);
    apb(1'b0, fcc_pkg::OFS_STATS, 32'h0);
    s0 = rdat;
    pulse(2);
    chk({relayA, lamps.auto}, 2'h1, "auto switch");
    apb(1'b1, fcc_pkg::OFS_CMD, 32'h1);
    tick(14);
    chk(relayA, 1'b1, "auto serial");
    apb(1'b1, fcc_pkg::OFS_CMD, 32'h4);
    tick(3);
    chk(relayA, 1'b0, "auto open");
    apb(1'b0, fcc_pkg::OFS_STATS, 32'h0);
    chk(rdat, s0, "test freeze");
    sw[0] <= 1'b0;
    $display("auto done");
  endtask : t_auto

  task t_trip;
    apb(1'b1, fcc_pkg::OFS_CMD, 32'h1);
    tick(6);
    apb(1'b1, fcc_pkg::OFS_EXT, 32'h7);
    tick(3);
    chk({relayA, lamps.tripped, msgSel}, 4'h7, "trip");
    chk({lamps.alarm, lamps.fault}, 2'h3, "alarm fault");
    apb(1'b1, fcc_pkg::OFS_CMD, 32'h1);
    tick(3);
    chk(relayA, 1'b0, "close when tripped");
    apb(1'b1, fcc_pkg::OFS_EXT, 32'h0);
    keys[2] <= 1'b1;
    anyKey <= 1'b1;
    tick(4);
    keys[2] <= 1'b0;
    anyKey <= 1'b0;
    tick(4);
    chk(lamps.tripped, 1'b0, "trip reset");
    tick(1010);
    chk(msgSel, fcc_pkg::MSG_STATUS, "idle default");
    $display("trip done");
  endtask : t_trip

  task t_weld;
    apb(1'b1, fcc_pkg::OFS_CTRL, 32'h0);
    keys[1] <= 1'b1;
    tick(4);
    keys[1] <= 1'b0;
    tick(8);
    stuck <= 1'b1;
    keys[3] <= 1'b1;
    tick(4);
    keys[3] <= 1'b0;
    tick(40);
    apb(1'b0, fcc_pkg::OFS_STATUS, 32'h0);
    chk(rdat[9], 1'b1, "welded flag");
    stuck <= 1'b0;
    $display("weld done");
  endtask : t_weld

  // hard-wired auto: input 0 auto close a, input 1 permissive, input 2 interlock
  task t_hwauto;
    apb(1'b1, fcc_pkg::OFS_PSWMAP, 32'hF4);
    apb(1'b1, fcc_pkg::OFS_CTRL, 32'h4);
    prog[2] <= 1'b1;
    prog[0] <= 1'b1;
    tick(12);
    chk(relayA, 1'b0, "auto close w/o permissive");
    prog[1] <= 1'b1;
    tick(12);
    chk({relayA, lamps.auto}, 2'h3, "auto close with permissive");
    prog[1:0] <= 2'h0;
    tick(12);
    apb(1'b1, fcc_pkg::OFS_CMD, 32'h4);
    tick(3);
    chk(relayA, 1'b0, "hw auto open");
    $display("hwauto done");
  endtask : t_hwauto

  task print_verdict;
    $display("checks %0d mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : print_verdict

  // main sequence
  initial
  begin
    err_count = 0;
    checks_done = 0;
    srst = 1'b1;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    {sw, prog, keys, progRelay, esdRelay, anyKey, stuck} = '0;
    tick(3);
    srst <= 1'b0;
    tick(12);
    t_regs();
    t_manual();
    t_breaker();
    t_auto();
    t_trip();
    t_weld();
    t_hwauto();
    print_verdict();
  end

  // watchdog against a hang
  initial
  begin
    tick(20000);
    err_count++;
    print_verdict();
  end
endmodule : fcc_feeder_ctl_tb
